// ==== logic/itg_counter.sv ====
// One down-counter with gate handling, latch and byte readback
`timescale 1ns/1ps
module itg_counter (
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic        gate_pin,
    input  wire logic        cnt_clk_pin,
    input  wire logic        ctrl_wr,
    input  wire logic [2:0]  ctrl_mode,
    input  wire logic [1:0]  ctrl_fmt,
    input  wire logic        load_wr,
    input  wire logic [15:0] load_val,
    input  wire logic        latch_cmd,
    input  wire logic        rd_stb,
    output logic      [7:0]  rd_data,
    output logic             cnt_out,
    output logic             latch_held
);
    // ****************************************
    // Pin synchronisation
    // ****************************************
    itg_sync_if ev ();

    itg_pin_sync u_sync (
        .clk_sys     (clk_sys),
        .rst         (rst),
        .gate_pin    (gate_pin),
        .cnt_clk_pin (cnt_clk_pin),
        .ev          (ev)
    );

    // ****************************************
    // Mode decode
    // ****************************************
    function automatic logic is_periodic(input logic [2:0] m);
        return m[1];
    endfunction

    function automatic logic is_triggered(input logic [2:0] m);
        return (m == itg_pkg::MODE_ONESHOT) || (m == itg_pkg::MODE_HWSTROBE);
    endfunction

    itg_pkg::itg_state_e state_q;
    itg_pkg::itg_state_e state_d;
    logic [2:0]  mode_q;
    logic [1:0]  fmt_q;
    logic [15:0] count_q;
    logic [15:0] count_d;
    logic [15:0] reload_q;
    logic [15:0] latch_q;
    logic        latched_q;
    logic        loaded_q;
    logic        msb_next_q;
    logic        out_d;

    wire periodic  = is_periodic(mode_q);
    wire triggered = is_triggered(mode_q);
    wire square    = (mode_q[1:0] == 2'h3);
    wire tc_mode   = (mode_q == itg_pkg::MODE_TC);
    wire sw_strobe = (mode_q == itg_pkg::MODE_SWSTROBE);
    // Gate level only stalls the level-sensitive modes
    wire gate_ok   = triggered | ev.gate_lvl;
    wire restart   = ev.gate_rise & (periodic | sw_strobe | triggered);
    wire [15:0] step   = square ? itg_pkg::STEP_TWO : itg_pkg::STEP_ONE;
    wire [15:0] dec    = count_q - step;
    wire        at_end = square ? (count_q <= itg_pkg::STEP_TWO)
                                : (count_q == itg_pkg::STEP_ONE);
    wire        do_tick = (state_q == itg_pkg::ITG_RUN) & ev.cnt_tick & gate_ok;

    // ****************************************
    // Readback selection
    // ****************************************
    wire [15:0] rd_src    = latched_q ? latch_q : count_q;
    wire        take_msb  = (fmt_q == itg_pkg::FMT_MSB) |
                            ((fmt_q == itg_pkg::FMT_BOTH) & msb_next_q);
    wire [7:0]  rd_byte   = take_msb ? rd_src[15:8] : rd_src[7:0];
    wire        last_byte = (fmt_q != itg_pkg::FMT_BOTH) | msb_next_q;
    // Cleared count after a control word stays hidden until a load
    wire        rd_ok     = rd_stb & loaded_q;
    wire        latch_go  = latch_cmd & loaded_q &
                            (~latched_q | (rd_ok & last_byte));

    // ****************************************
    // Counting and gate control
    // ****************************************
    always_comb begin
        state_d = state_q;
        count_d = count_q;
        out_d   = cnt_out;
        if (load_wr) begin
            count_d = load_val;
            if (triggered) begin
                state_d = itg_pkg::ITG_ARMED;
            end else begin
                state_d = itg_pkg::ITG_RUN;
            end
        end else if (state_q != itg_pkg::ITG_IDLE && restart) begin
            count_d = reload_q;
            state_d = itg_pkg::ITG_RUN;
            if (triggered) begin
                out_d = 1'b0;
            end
        end else if (periodic && !ev.gate_lvl) begin
            out_d = 1'b1;
            if (state_q == itg_pkg::ITG_RUN) begin
                state_d = itg_pkg::ITG_ARMED;
            end
        end else if (sw_strobe && !ev.gate_lvl && state_q == itg_pkg::ITG_RUN) begin
            state_d = itg_pkg::ITG_ARMED;
        end else if (do_tick) begin
            count_d = dec;
            if (tc_mode && at_end) begin
                out_d = 1'b1;
            end else if (periodic && at_end) begin
                count_d = reload_q;
                out_d   = square ? ~cnt_out : 1'b1;
            end else if (mode_q[1:0] == 2'h2 && count_q == itg_pkg::STEP_TWO) begin
                out_d = 1'b0;
            end else if (!periodic && !tc_mode && at_end) begin
                out_d = ~triggered;
            end else if (!periodic && !tc_mode) begin
                out_d = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_q  <= itg_pkg::ITG_IDLE;
            count_q  <= itg_pkg::COUNT_RST;
            reload_q <= itg_pkg::COUNT_RST;
            mode_q   <= itg_pkg::MODE_RST;
            fmt_q    <= itg_pkg::FMT_RST;
            loaded_q <= 1'b0;
            cnt_out  <= 1'b0;
        end else if (ctrl_wr) begin
            state_q  <= itg_pkg::ITG_IDLE;
            count_q  <= itg_pkg::COUNT_RST;
            mode_q   <= ctrl_mode;
            fmt_q    <= ctrl_fmt;
            loaded_q <= 1'b0;
            cnt_out  <= (ctrl_mode != itg_pkg::MODE_TC);
        end else begin
            state_q  <= state_d;
            count_q  <= count_d;
            cnt_out  <= out_d;
            if (load_wr) begin
                reload_q <= load_val;
                loaded_q <= 1'b1;
            end
        end
    end

    // ****************************************
    // Latch and byte readback
    // ****************************************
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            latch_q    <= itg_pkg::COUNT_RST;
            latched_q  <= 1'b0;
            msb_next_q <= 1'b0;
            rd_data    <= itg_pkg::RDATA_RST;
        end else if (ctrl_wr) begin
            latched_q  <= 1'b0;
            msb_next_q <= 1'b0;
        end else begin
            if (rd_ok) begin
                rd_data    <= rd_byte;
                msb_next_q <= (fmt_q == itg_pkg::FMT_BOTH) & ~msb_next_q;
            end
            // A new latch in the cycle of the last read wins over the release
            if (latch_go) begin
                latch_q   <= count_q;
                latched_q <= 1'b1;
            end else if (rd_ok && last_byte) begin
                latched_q <= 1'b0;
            end
        end
    end

    assign latch_held = latched_q;
endmodule // itg_counter

// ==== logic/itg_pin_sync.sv ====
// Two-stage synchronisers and edge detection for gate and counter clock pins
`timescale 1ns/1ps
module itg_pin_sync (
    input  wire logic  clk_sys,
    input  wire logic  rst,
    input  wire logic  gate_pin,
    input  wire logic  cnt_clk_pin,
    itg_sync_if.src    ev
);
    // ****************************************
    // Synchronisers
    // ****************************************
    logic [itg_pkg::SYNC_STAGES-1:0] gate_sync_q;
    logic [itg_pkg::SYNC_STAGES-1:0] clk_sync_q;
    logic                            gate_prev_q;
    logic                            clk_prev_q;
    logic                            gate_rise_d;
    logic                            tick_d;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            gate_sync_q <= '0;
            clk_sync_q  <= '0;
        end else begin
            gate_sync_q <= {gate_sync_q[itg_pkg::SYNC_STAGES-2:0], gate_pin};
            clk_sync_q  <= {clk_sync_q[itg_pkg::SYNC_STAGES-2:0], cnt_clk_pin};
        end
    end

    // ****************************************
    // Edge detection on the second stage only
    // ****************************************
    assign gate_rise_d = gate_sync_q[itg_pkg::SYNC_STAGES-1] & ~gate_prev_q;
    // Counting happens on the falling edge of the counter clock
    assign tick_d      = ~clk_sync_q[itg_pkg::SYNC_STAGES-1] & clk_prev_q;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            gate_prev_q  <= 1'b0;
            clk_prev_q   <= 1'b0;
            ev.gate_lvl  <= 1'b0;
            ev.gate_rise <= 1'b0;
            ev.cnt_tick  <= 1'b0;
        end else begin
            gate_prev_q  <= gate_sync_q[itg_pkg::SYNC_STAGES-1];
            clk_prev_q   <= clk_sync_q[itg_pkg::SYNC_STAGES-1];
            ev.gate_lvl  <= gate_sync_q[itg_pkg::SYNC_STAGES-1];
            ev.gate_rise <= gate_rise_d;
            ev.cnt_tick  <= tick_d;
        end
    end
endmodule // itg_pin_sync

// ==== logic/itg_pkg.sv ====
// Constants and types for the interval timer gate and readback counter
// What this block does
// - Rate and square modes: low gate halts, forces output high; rising gate restarts.
// - One-shot and hardware strobe: rising gate starts, or retriggers from the loaded value.
// - Counting is downward; square wave mode steps by two per counted clock.
// - Latch command freezes a copy of the count; counting goes on undisturbed.
// - Terminal-count mode: low gate suspends, high gate resumes from held value.
// - Software strobe: low gate stops; high gate restarts from the loaded count.
// - Control word clears the count to zero; that cleared value is never readable.
package itg_pkg;
    localparam int          SYNC_STAGES   = 2;
    localparam logic [15:0] COUNT_RST     = 16'h0000;
    localparam logic [7:0]  RDATA_RST     = 8'h00;
    localparam logic [2:0]  MODE_RST      = 3'h0;
    localparam logic [1:0]  FMT_RST       = 2'h3;
    localparam logic [15:0] STEP_ONE      = 16'h0001;
    localparam logic [15:0] STEP_TWO      = 16'h0002;
    // Readback formats; loads always take all 16 bits
    localparam logic [1:0]  FMT_LSB       = 2'h1;
    localparam logic [1:0]  FMT_MSB       = 2'h2;
    localparam logic [1:0]  FMT_BOTH      = 2'h3;
    // Mode codes; bit 1 set selects rate or square whatever bit 2 holds
    localparam logic [2:0]  MODE_TC       = 3'h0;
    localparam logic [2:0]  MODE_ONESHOT  = 3'h1;
    localparam logic [2:0]  MODE_SWSTROBE = 3'h4;
    localparam logic [2:0]  MODE_HWSTROBE = 3'h5;

    typedef enum logic [2:0] {
        ITG_IDLE  = 3'b001,
        ITG_ARMED = 3'b010,
        ITG_RUN   = 3'b100
    } itg_state_e;
endpackage

// ==== logic/itg_sync_if.sv ====
// Carrier for synchronised gate and counter clock events
`timescale 1ns/1ps
interface itg_sync_if;
    logic gate_lvl;
    logic gate_rise;
    logic cnt_tick;
    modport src (output gate_lvl, output gate_rise, output cnt_tick);
    modport dst (input gate_lvl, input gate_rise, input cnt_tick);
endinterface

// ==== verif/interval_timer_gate_readback_bench.sv ====
// Self-checking bench for the gated counter with latch readback
`timescale 1ns/1ps
module interval_timer_gate_readback_bench;
    logic        clk_sys, rst, gate_pin, cnt_clk_pin, ctrl_wr, load_wr, latch_cmd, rd_stb, cnt_out, latch_held;
    logic [2:0]  ctrl_mode;
    logic [1:0]  ctrl_fmt;
    logic [7:0]  rd_data, lo, hi;
    logic [15:0] load_val;
    int          err_count, check_count, cyc, cnt_m, ld_m, mode_m, run_m, k;
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    itg_counter DUT (.clk_sys(clk_sys), .rst(rst), .gate_pin(gate_pin), .cnt_clk_pin(cnt_clk_pin),
        .ctrl_wr(ctrl_wr), .ctrl_mode(ctrl_mode), .ctrl_fmt(ctrl_fmt), .load_wr(load_wr), .load_val(load_val),
        .latch_cmd(latch_cmd), .rd_stb(rd_stb), .rd_data(rd_data), .cnt_out(cnt_out), .latch_held(latch_held));
    itg_host host (.clk_sys(clk_sys), .rd_data(rd_data), .ctrl_wr(ctrl_wr), .ctrl_mode(ctrl_mode),
        .ctrl_fmt(ctrl_fmt), .load_wr(load_wr), .load_val(load_val), .latch_cmd(latch_cmd), .rd_stb(rd_stb));
    task automatic chk(input string n, input int e, input logic [15:0] g);
        check_count++;
        if (g !== e[15:0]) begin
            err_count++;
            $display("unexpected %s: expected %h seen %h", n, e[15:0], g);
        end
    endtask
    // Counter clock pulses; idle high so reads see a still count
    task automatic tick(input int n);
        repeat (n) begin
            cnt_clk_pin = 1'b0;
            repeat (4) @(posedge clk_sys);
            #2 cnt_clk_pin = 1'b1;
            repeat (4) @(posedge clk_sys);
            #2;
            if (run_m && (gate_pin || mode_m == 1 || mode_m == 5)) cnt_m = (cnt_m - (mode_m == 3 ? 2 : 1)) & 'hFFFF;
        end
    endtask
    task automatic gate(input logic v);
        if (v && !gate_pin && mode_m != 0) begin
            cnt_m = ld_m;
            run_m = 1;
        end
        gate_pin = v;
        repeat (6) @(posedge clk_sys);
        #2;
    endtask
    task automatic setup(input int m, input logic [15:0] v);
        host.cfg(m[2:0], itg_pkg::FMT_BOTH);
        host.load(v);
        {mode_m, ld_m, cnt_m, run_m} = {m, int'(v), int'(v), int'(m != 1 && m != 5)};
    endtask
    task automatic rd16(input int e);
        host.rd(lo);
        host.rd(hi);
        chk("count", e, {hi, lo});
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            give_verdict();
        end
    end
    initial begin
        {rst, gate_pin, cnt_clk_pin} = 3'b111;
        {err_count, check_count, cyc, mode_m, run_m} = '0;
        k = $urandom(32'h99602f5f);
        repeat (10) @(posedge clk_sys);
        #2 rst = 1'b0;
        for (int m = 0; m < 6; m++) begin
            gate(m != 1 && m != 5);
            setup(m, (16'h0100 + $urandom % 16'h7000) & 16'hFFFE);
            gate(1'b1);
            tick(1 + $urandom % 4);
            rd16(cnt_m);
            gate(1'b0);
            if (m == 2 || m == 3) chk("out", 1, {15'h0, cnt_out});
            tick(2);
            gate(1'b1);
            tick(1);
            rd16(cnt_m);
            $display("mode %0d test done", m);
        end
        // Short square period so the output is low when the gate drops
        setup(3, 16'h0004);
        tick(2);
        chk("out", 0, {15'h0, cnt_out});
        gate(1'b0);
        chk("out", 1, {15'h0, cnt_out});
        gate(1'b1);
        $display("square gate test done");
        // Upper half of a chained pair, clocked by a modelled rate counter
        setup(0, 16'(16'h0200 + $urandom % 16'h0100));
        repeat (3) begin
            repeat (5) @(posedge clk_sys);
            #2 tick(1);
        end
        rd16(cnt_m);
        $display("chain test done");
        k = cnt_m >> 8;
        host.cfg(3'h2, itg_pkg::FMT_BOTH);
        host.rd(lo);
        chk("refused", k, {8'h00, lo});
        setup(2, $urandom % 16'h7000 + 16'h0100);
        host.latch();
        tick(3);
        host.latch();
        chk("held", 1, {15'h0, latch_held});
        rd16(ld_m);
        rd16(cnt_m);
        host.cfg(3'h2, itg_pkg::FMT_LSB);
        host.latch();
        chk("held", 0, {15'h0, latch_held});
        host.load(16'h0055);
        host.latch();
        host.rd(lo);
        chk("lsb", 'h55, {8'h00, lo});
        chk("held", 0, {15'h0, latch_held});
        host.latch();
        chk("held", 1, {15'h0, latch_held});
        host.cfg(3'h2, itg_pkg::FMT_MSB);
        chk("held", 0, {15'h0, latch_held});
        host.load(16'hA955);
        host.rd(hi);
        chk("msb", 'hA9, {8'h00, hi});
        $display("latch test done");
        give_verdict();
    end
endmodule // interval_timer_gate_readback_bench

// ==== verif/itg_counter_asserts.sv ====
// Port-level checker for gate handling and latch readback
`timescale 1ns/1ps
module itg_counter_asserts (
    input wire logic        clk_sys,
    input wire logic        rst,
    input wire logic        gate_pin,
    input wire logic        ctrl_wr,
    input wire logic [2:0]  ctrl_mode,
    input wire logic        load_wr,
    input wire logic        latch_cmd,
    input wire logic        rd_stb,
    input wire logic [7:0]  rd_data,
    input wire logic        cnt_out,
    input wire logic        latch_held
);
    logic mode1_q;
    logic cfg_q;
    logic ld_q;
    // Settings the ports do not show directly
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) {mode1_q, cfg_q, ld_q} <= 3'h0;
        else if (ctrl_wr) {mode1_q, cfg_q, ld_q} <= {ctrl_mode[1], 2'b10};
        else if (load_wr) {cfg_q, ld_q} <= 2'b01;
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    a_latch_take: assert property (latch_cmd && ld_q && !latch_held && !ctrl_wr && !load_wr |=> latch_held)
        else $error("latch not taken");
    a_latch_keep: assert property (latch_held && !rd_stb && !ctrl_wr |=> latch_held)
        else $error("latch dropped early");
    a_latch_early: assert property (!ld_q && latch_cmd && !load_wr && !latch_held |=> !latch_held)
        else $error("latch before load");
    a_ctrl_drop: assert property (ctrl_wr && !latch_cmd |=> !latch_held)
        else $error("latch kept over control");
    a_rd_refused: assert property (cfg_q && rd_stb && !load_wr |=> $stable(rd_data))
        else $error("read not refused");
    a_rd_steady: assert property (!rd_stb |=> $stable(rd_data))
        else $error("read data moved");
    a_gate_high: assert property ((mode1_q && !gate_pin && !ctrl_wr) [*5] |-> cnt_out)
        else $error("output not forced high");
    a_tc_low: assert property (ctrl_wr && ctrl_mode == itg_pkg::MODE_TC |=> !cnt_out)
        else $error("terminal mode output not low");
    cover property (latch_held && rd_stb);
    cover property (cfg_q && rd_stb);
    cover property (mode1_q && !gate_pin && cnt_out);
endmodule // itg_counter_asserts
bind itg_counter itg_counter_asserts u_chk (.clk_sys(clk_sys), .rst(rst), .gate_pin(gate_pin),
    .ctrl_wr(ctrl_wr), .ctrl_mode(ctrl_mode), .load_wr(load_wr), .latch_cmd(latch_cmd), .rd_stb(rd_stb),
    .rd_data(rd_data), .cnt_out(cnt_out), .latch_held(latch_held));

// ==== verif/itg_host.sv ====
// Host model driving the counter's command strobes
`timescale 1ns/1ps
module itg_host (
    input  wire logic        clk_sys,
    input  wire logic [7:0]  rd_data,
    output logic             ctrl_wr,
    output logic      [2:0]  ctrl_mode,
    output logic      [1:0]  ctrl_fmt,
    output logic             load_wr,
    output logic      [15:0] load_val,
    output logic             latch_cmd,
    output logic             rd_stb
);
    initial begin
        {ctrl_wr, load_wr, latch_cmd, rd_stb} = 4'h0;
        ctrl_mode = 3'h0;
        ctrl_fmt = 2'h3;
        load_val = 16'h0000;
    end
    // One-cycle strobe, qualifiers held around it
    task automatic strobe(input logic [3:0] s);
        @(posedge clk_sys) #2;
        {ctrl_wr, load_wr, latch_cmd, rd_stb} = s;
        @(posedge clk_sys) #2;
        {ctrl_wr, load_wr, latch_cmd, rd_stb} = 4'h0;
    endtask
    task automatic cfg(input logic [2:0] m, input logic [1:0] f);
        ctrl_mode = m;
        ctrl_fmt = f;
        strobe(4'h8);
        ctrl_mode = ~m;
    endtask
    task automatic load(input logic [15:0] v);
        load_val = v;
        strobe(4'h4);
        load_val = ~v;
    endtask
    task automatic latch();
        strobe(4'h2);
    endtask
    task automatic rd(output logic [7:0] b);
        strobe(4'h1);
        @(posedge clk_sys) #1;
        b = rd_data;
    endtask
endmodule // itg_host
